/* pad_alarm.v */
// one alarm channel: low, high and hysteresis evaluation
`timescale 1ns/10ps
`default_nettype none
`include "pad_defs.vh"
module pad_alarm (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        upd,
  input  wire [31:0] value,
  input  wire        gate_ok,
  input  wire [31:0] lo_sp,
  input  wire [31:0] hi_sp,
  input  wire [31:0] hyst,
  input  wire [2:0]  en,
  output reg         active_q
);
  reg         lo_q;
  reg         hi_q;
  reg         lo_d;
  reg         hi_d;
  reg  [31:0] h;

  always @* begin
    h = en[`PAD_EN_HYS] ? hyst : 32'h0;
    if (!gate_ok || !en[`PAD_EN_LO])
      lo_d = 1'b0;
    else if (lo_q)
      lo_d = $signed(value) < $signed(lo_sp + h);
    else
      lo_d = $signed(value) < $signed(lo_sp);
    if (!gate_ok || !en[`PAD_EN_HI])
      hi_d = 1'b0;
    else if (hi_q)
      hi_d = $signed(value) > $signed(hi_sp - h);
    else
      hi_d = $signed(value) > $signed(hi_sp);
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_q     <= 1'b0;
      hi_q     <= 1'b0;
      active_q <= 1'b0;
    end else if (upd) begin
      lo_q     <= lo_d;
      hi_q     <= hi_d;
      active_q <= lo_d | hi_d;
    end
  end
endmodule
`default_nettype wire

/* pad_asserts.sv */
// concurrent checks on the process display top ports
`timescale 1ns/10ps
`default_nettype none
module pad_asserts (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       pv_we,
  input wire logic       bus_power,
  input wire logic       cfg_we,
  input wire logic       sp_next,
  input wire logic       sp_commit,
  input wire logic       qa_req,
  input wire logic       disp_req,
  input wire logic [5:0] alarm_closed_q,
  input wire logic       disp_done_q,
  input wire logic [2:0] sp_digit_ptr_q,
  input wire logic       menu_up_q,
  input wire logic       qa_grant_q,
  input wire logic       qa_deny_q,
  input wire logic       qa_mode_q,
  input wire logic [3:0] screen_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since anything that may move an alarm contact
  logic [2:0] quiet_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      quiet_q <= 3'h0;
    else if (pv_we || cfg_we || $changed(bus_power))
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  end
  sequence s_fmt_req; disp_req; endsequence
  sequence s_fmt_done; ##[1:24] disp_done_q; endsequence
  property p_pwr_off; !bus_power [*3] |=> alarm_closed_q == 6'h00; endproperty
  property p_quiet; quiet_q >= 3'h4 |-> $stable(alarm_closed_q); endproperty
  property p_menu_up; sp_commit |=> menu_up_q && sp_digit_ptr_q == 3'h0; endproperty
  property p_ptr_step;
    sp_next && !sp_commit |=> sp_digit_ptr_q ==
      (($past(sp_digit_ptr_q) == 3'h5) ? 3'h0 : $past(sp_digit_ptr_q) + 3'h1);
  endproperty
  property p_grant; qa_grant_q |-> $past(qa_req) && !$past(qa_mode_q) ##1 qa_mode_q; endproperty
  property p_deny; qa_deny_q |-> $past(qa_req) && !qa_mode_q && !qa_grant_q; endproperty
  property p_fmt; s_fmt_req |-> s_fmt_done; endproperty
  property p_screen; screen_q >= 4'h1 && screen_q <= 4'hB; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("contact closed without power");
  a_quiet: assert property (p_quiet) else $error("contact moved with no cause");
  a_menu_up: assert property (p_menu_up) else $error("commit did not return");
  a_ptr_step: assert property (p_ptr_step) else $error("digit pointer step wrong");
  a_grant: assert property (p_grant) else $error("grant without request");
  a_deny: assert property (p_deny) else $error("deny without request");
  a_fmt: assert property (p_fmt) else $error("format never finished");
  a_screen: assert property (p_screen) else $error("screen out of range");
endmodule
bind pad_top pad_asserts pad_asserts_i (.*);
`default_nettype wire

/* pad_defs.vh */
// constants for the process alarm display block
`ifndef PAD_DEFS_VH
`define PAD_DEFS_VH
`define PAD_CFG_GAIN     4'h0
`define PAD_CFG_OFFSET   4'h1
`define PAD_CFG_FORMAT   4'h2
`define PAD_CFG_BARGRAPH_LOWER_LIMIT   4'h3
`define PAD_CFG_BARGRAPH_UPPER_LIMIT   4'h4
`define PAD_CFG_TAG      4'h5
`define PAD_CFG_UNIT     4'h6
`define PAD_CFG_ASRC     4'h7
`define PAD_CFG_APOL     4'h8
`define PAD_CFG_AEN      4'h9
`define PAD_CFG_SCREEN   4'hA
`define PAD_CFG_GLOBAL   4'hB
`define PAD_CFG_QCODE    4'hC
`define PAD_GL_GOOD_ONLY 0
`define PAD_GL_STAT_TXT  1
`define PAD_GL_QUICK_EN  2
`define PAD_GL_FONT_LO   3
`define PAD_EN_LO        0
`define PAD_EN_HI        1
`define PAD_EN_HYS       2
`define PAD_SP_LO        2'h0
`define PAD_SP_HI        2'h1
`define PAD_SP_HYS       2'h2
`define PAD_FMT_AUTO     3'h0
`define PAD_FMT_DP0      3'h5
`define PAD_RST_GAIN     16'h0100
`define PAD_RST_BARGRAPH_UPPER_LIMIT   32'h000F4240
`define PAD_RST_SCREEN   4'h1
`define PAD_RST_BRIGHT   7'h64
`define PAD_RST_CONTRAST 7'h32
`define PAD_RST_QCODE    32'h30303030
`define PAD_RST_CHAR     8'h20
`define PAD_SP_SCALE     100
`define PAD_FLASH_HALF_MS 500
`define PAD_CLK_KHZ      25000
`endif

/* pad_fmt.v */
// formats one scaled value into right aligned characters
`timescale 1ns/10ps
`default_nettype none
`include "pad_defs.vh"
module pad_fmt (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         start,
  input  wire [31:0]  value,
  input  wire [4:0]   ndig,
  input  wire [2:0]   fmt,
  output reg          busy_q,
  output reg          done_q,
  output reg          over_q,
  output reg  [2:0]   dp_q,
  output reg  [135:0] chars_q
);
  localparam ST_IDLE = 2'd0;
  localparam ST_TRY  = 2'd1;
  localparam ST_EMIT = 2'd2;

  reg  [1:0]  st_q;
  reg  [31:0] mag_q;
  reg  [31:0] v_q;
  reg         neg_q;
  reg         auto_q;
  reg  [4:0]  ndig_q;
  reg  [4:0]  need_q;
  reg  [4:0]  pos_q;
  reg  [7:0]  ch;
  wire [31:0] tv = mag_q / div_of(dp_q);
  wire [31:0] rem = v_q % 32'd10;
  wire [4:0]  tn = len10(tv);
  wire [4:0]  tmin = {2'b00, dp_q} + 5'd1;
  wire [4:0]  need_w = ((tn > tmin) ? tn : tmin) + {4'h0, neg_q};

  function [31:0] div_of;
    input [2:0] d;
    integer k;
    begin
      div_of = 32'd1;
      for (k = 0; k < 4; k = k + 1)
        if (k >= d)
          div_of = div_of * 32'd10;
    end
  endfunction

  function [4:0] len10;
    input [31:0] x;
    integer   k;
    reg [31:0] p;
    begin
      len10 = 5'd1;
      p = 32'd10;
      for (k = 2; k <= 10; k = k + 1) begin
        if (x >= p)
          len10 = k[4:0];
        if (k < 10)
          p = p * 32'd10;
      end
    end
  endfunction

  always @* begin
    // overrange fills shown digits with question marks
    if (over_q)
      ch = (pos_q < ndig_q) ? 8'h3F : `PAD_RST_CHAR;
    // only needed digits are drawn, zero filled to dp_q plus one digits, rest blank
    else if (pos_q < need_q - {4'h0, neg_q})
      ch = {4'h3, rem[3:0]};
    // sign sits in the digit left of the magnitude
    else if (neg_q && pos_q == need_q - 5'd1)
      ch = 8'h2D;
    else
      ch = `PAD_RST_CHAR;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      mag_q <= 32'h0;
      v_q <= 32'h0;
      neg_q <= 1'b0;
      auto_q <= 1'b0;
      ndig_q <= 5'h0;
      need_q <= 5'h0;
      pos_q <= 5'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      over_q <= 1'b0;
      dp_q <= 3'h0;
      chars_q <= 136'h0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            neg_q <= value[31];
            mag_q <= value[31] ? (~value + 32'd1) : value;
            ndig_q <= ndig;
            auto_q <= (fmt == `PAD_FMT_AUTO);
            // auto starts at four fraction digits
            dp_q <= (fmt == `PAD_FMT_AUTO) ? 3'd4 : (`PAD_FMT_DP0 - fmt);
            over_q <= 1'b0;
            busy_q <= 1'b1;
            st_q <= ST_TRY;
          end
        end
        ST_TRY: begin
          pos_q <= 5'h0;
          v_q <= tv;
          need_q <= need_w;
          if (need_w <= ndig_q) begin
            st_q <= ST_EMIT;
          end else if (auto_q && dp_q != 3'd0) begin
            dp_q <= dp_q - 3'd1;
          end else begin
            over_q <= 1'b1;
            st_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          chars_q[{pos_q, 3'b000} +: 8] <= ch;
          v_q <= v_q / 32'd10;
          pos_q <= pos_q + 5'd1;
          if (pos_q == 5'd16) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* pad_host.sv */
// fieldbus host model driving process values and bus power
`timescale 1ns/10ps
`default_nettype none
module pad_host (
  input  wire logic   core_clk,
  output logic        pv_we,
  output logic [2:0]  pv_idx,
  output logic [31:0] pv_value,
  output logic        pv_good,
  output logic        bus_power
);
  initial begin
    {pv_we, pv_idx, pv_value, pv_good, bus_power} = 38'h1;
  end
  // qualifiers are scrambled once the strobe is gone
  task send(input [2:0] i, input [31:0] v, input g);
    @(posedge core_clk);
    {pv_we, pv_idx, pv_value, pv_good} <= {1'b1, i, v, g};
    @(posedge core_clk);
    {pv_we, pv_idx, pv_value, pv_good} <= {1'b0, ~i, ~v, ~g};
  endtask
  task set_power(input p);
    @(posedge core_clk);
    bus_power <= p;
  endtask
endmodule
`default_nettype wire

/* pad_top.v */
// scaling, formatting, alarms and quick access of the process display
`timescale 1ns/10ps
`default_nettype none
`include "pad_defs.vh"
module pad_top #(
  parameter FLASH_HALF_CYC = `PAD_FLASH_HALF_MS * `PAD_CLK_KHZ
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         pv_we,
  input  wire [2:0]   pv_idx,
  input  wire [31:0]  pv_value,
  input  wire         pv_good,
  input  wire         bus_power,
  input  wire         cfg_we,
  input  wire [3:0]   cfg_sel,
  input  wire [2:0]   cfg_var,
  input  wire [3:0]   cfg_pos,
  input  wire [31:0]  cfg_data,
  input  wire         sp_digit_we,
  input  wire [3:0]   sp_digit_val,
  input  wire         sp_next,
  input  wire         sp_commit,
  input  wire [2:0]   sp_chan,
  input  wire [1:0]   sp_kind,
  input  wire         sp_neg,
  input  wire         qa_req,
  input  wire [31:0]  qa_code,
  input  wire         qa_we,
  input  wire [6:0]   qa_bright,
  input  wire [6:0]   qa_contrast,
  input  wire         qa_exit,
  input  wire         disp_req,
  input  wire [2:0]   disp_idx,
  input  wire [2:0]   txt_idx,
  input  wire [3:0]   txt_pos,
  input  wire         txt_unit,
  input  wire [2:0]   summ_chan,
  output reg  [5:0]   alarm_closed_q,
  output reg  [7:0]   var_invert_q,
  output reg  [135:0] disp_chars_q,
  output reg  [2:0]   disp_dp_q,
  output reg          disp_over_q,
  output reg          disp_done_q,
  output reg          status_show_q,
  output reg          status_good_q,
  output reg  [7:0]   txt_char_q,
  output reg  [7:0]   summ_q,
  output reg  [2:0]   sp_digit_ptr_q,
  output reg          menu_up_q,
  output reg          qa_grant_q,
  output reg          qa_deny_q,
  output reg          qa_mode_q,
  output reg  [6:0]   bright_q,
  output reg  [6:0]   contrast_q,
  output reg  [3:0]   screen_q
);
  reg  [15:0] gain_q [0:7];
  reg  [31:0] offset_q [0:7];
  reg  [2:0]  fmt_q [0:7];
  reg  [31:0] bargraph_lower_limit_q [0:7];
  reg  [31:0] bargraph_upper_limit_q [0:7];
  reg  [31:0] scaled_q [0:7];
  reg  [7:0]  good_q;
  reg  [7:0]  tag_q [0:127];
  reg  [7:0]  unit_q [0:63];
  reg  [2:0]  asrc_q [0:5];
  reg  [2:0]  aen_q [0:5];
  reg  [5:0]  apol_q;
  reg  [31:0] sp_lo_q [0:5];
  reg  [31:0] sp_hi_q [0:5];
  reg  [31:0] hyst_q [0:5];
  reg  [3:0]  dig_q [0:5];
  reg         good_only_q;
  reg         stat_txt_q;
  reg         quick_en_q;
  reg  [1:0]  font_q;
  reg  [31:0] qcode_q;
  reg  [47:0] prod_q;
  reg  [2:0]  prod_idx_q;
  reg         prod_v_q;
  reg         prod_good_q;
  reg         pwr_s1_q;
  reg         pwr_s2_q;
  reg  [23:0] flash_cnt_q;
  reg         flash_ph_q;
  reg  [2:0]  disp_var_q;
  reg  [7:0]  var_alarm;
  reg  [31:0] sp_val;
  wire [31:0] sc_new = prod_q[39:8] + offset_q[prod_idx_q];
  wire [5:0]  act;
  wire        f_busy;
  wire        f_done;
  wire        f_over;
  wire [2:0]  f_dp;
  wire [135:0] f_chars;
  wire        cfg_ok = cfg_we && !qa_mode_q;
  integer     i;
  integer     j;
  integer     k_sp;
  integer     k_al;

  function [4:0] screen_digits;
    input [3:0] scr;
    input [1:0] font;
    begin
      case (scr)
        4'd1, 4'd5: begin
          case (font)
            2'd0: screen_digits = 5'd5;
            2'd1: screen_digits = 5'd7;
            2'd2: screen_digits = 5'd11;
            default: screen_digits = 5'd17;
          endcase
        end
        4'd2, 4'd6: screen_digits = 5'd7;
        4'd7, 4'd9: screen_digits = 5'd6;
        4'd8, 4'd10: screen_digits = 5'd4;
        default: screen_digits = 5'd5;
      endcase
    end
  endfunction

  // entered digits assembled into the committed value
  always @* begin
    sp_val = 32'h0;
    for (k_sp = 0; k_sp < 6; k_sp = k_sp + 1)
      sp_val = sp_val * 32'd10 + {28'h0, dig_q[k_sp]};
    sp_val = sp_val * `PAD_SP_SCALE;
    if (sp_neg)
      sp_val = ~sp_val + 32'd1;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        gain_q[i] <= `PAD_RST_GAIN;
        offset_q[i] <= 32'h0;
        fmt_q[i] <= `PAD_FMT_AUTO;
        bargraph_lower_limit_q[i] <= 32'h0;
        bargraph_upper_limit_q[i] <= `PAD_RST_BARGRAPH_UPPER_LIMIT;
      end
      for (i = 0; i < 128; i = i + 1)
        tag_q[i] <= `PAD_RST_CHAR;
      for (i = 0; i < 64; i = i + 1)
        unit_q[i] <= `PAD_RST_CHAR;
      for (i = 0; i < 6; i = i + 1) begin
        asrc_q[i] <= 3'h0;
        aen_q[i] <= 3'h0;
        sp_lo_q[i] <= 32'h0;
        sp_hi_q[i] <= 32'h0;
        hyst_q[i] <= 32'h0;
        dig_q[i] <= 4'h0;
      end
      apol_q <= 6'h3F;
      screen_q <= `PAD_RST_SCREEN;
      good_only_q <= 1'b1;
      stat_txt_q <= 1'b1;
      quick_en_q <= 1'b1;
      font_q <= 2'h0;
      qcode_q <= `PAD_RST_QCODE;
      sp_digit_ptr_q <= 3'h0;
      menu_up_q <= 1'b0;
    end else begin
      menu_up_q <= 1'b0;
      if (cfg_ok) begin
        case (cfg_sel)
          `PAD_CFG_GAIN:   gain_q[cfg_var] <= cfg_data[15:0];
          `PAD_CFG_OFFSET: offset_q[cfg_var] <= cfg_data;
          `PAD_CFG_FORMAT: fmt_q[cfg_var] <= cfg_data[2:0];
          `PAD_CFG_BARGRAPH_LOWER_LIMIT: bargraph_lower_limit_q[cfg_var] <= cfg_data;
          `PAD_CFG_BARGRAPH_UPPER_LIMIT: bargraph_upper_limit_q[cfg_var] <= cfg_data;
          // label stored one character at a time
          `PAD_CFG_TAG:    tag_q[{cfg_var, cfg_pos}] <= cfg_data[7:0];
          // unit string stored one character at a time
          `PAD_CFG_UNIT:   unit_q[{cfg_var, cfg_pos[2:0]}] <= cfg_data[7:0];
          `PAD_CFG_ASRC:   if (cfg_var < 3'd6) asrc_q[cfg_var] <= cfg_data[2:0];
          `PAD_CFG_APOL:   if (cfg_var < 3'd6) apol_q[cfg_var] <= cfg_data[0];
          `PAD_CFG_AEN:    if (cfg_var < 3'd6) aen_q[cfg_var] <= cfg_data[2:0];
          `PAD_CFG_SCREEN: if (cfg_data[3:0] >= 4'd1 && cfg_data[3:0] <= 4'd11)
                             screen_q <= cfg_data[3:0];
          `PAD_CFG_GLOBAL: begin
            good_only_q <= cfg_data[`PAD_GL_GOOD_ONLY];
            stat_txt_q <= cfg_data[`PAD_GL_STAT_TXT];
            quick_en_q <= cfg_data[`PAD_GL_QUICK_EN];
            font_q <= cfg_data[`PAD_GL_FONT_LO +: 2];
          end
          `PAD_CFG_QCODE:  qcode_q <= cfg_data;
          default: ;
        endcase
      end
      // one digit active, next key advances, commit moves up
      if (sp_digit_we)
        dig_q[sp_digit_ptr_q] <= sp_digit_val;
      if (sp_commit) begin
        if (sp_chan < 3'd6) begin
          case (sp_kind)
            `PAD_SP_LO:  sp_lo_q[sp_chan] <= sp_val;
            `PAD_SP_HI:  sp_hi_q[sp_chan] <= sp_val;
            `PAD_SP_HYS: hyst_q[sp_chan] <= sp_val;
            default: ;
          endcase
        end
        sp_digit_ptr_q <= 3'h0;
        menu_up_q <= 1'b1;
      end else if (sp_next) begin
        sp_digit_ptr_q <= (sp_digit_ptr_q == 3'd5) ? 3'h0 : sp_digit_ptr_q + 3'd1;
      end
    end
  end

  // multiply by gain then add signed offset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prod_q <= 48'h0;
      prod_idx_q <= 3'h0;
      prod_v_q <= 1'b0;
      prod_good_q <= 1'b0;
      good_q <= 8'h0;
      for (j = 0; j < 8; j = j + 1)
        scaled_q[j] <= 32'h0;
    end else begin
      prod_v_q <= pv_we;
      if (pv_we) begin
        prod_q <= $signed(pv_value) * $signed(gain_q[pv_idx]);
        prod_idx_q <= pv_idx;
        prod_good_q <= pv_good;
      end
      if (prod_v_q) begin
        scaled_q[prod_idx_q] <= sc_new;
        good_q[prod_idx_q] <= prod_good_q;
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : g_alarm
      // per-channel settings, the scaled value and the global good-only setting reach the channel
      pad_alarm u_alarm (
        .core_clk (core_clk),
        .rst      (rst),
        .upd      (prod_v_q && prod_idx_q == asrc_q[c]),
        .value    (sc_new),
        .gate_ok  (!good_only_q || prod_good_q),
        .lo_sp    (sp_lo_q[c]),
        .hi_sp    (sp_hi_q[c]),
        .hyst     (hyst_q[c]),
        .en       (aen_q[c]),
        .active_q (act[c])
      );
    end
  endgenerate

  always @* begin
    var_alarm = 8'h0;
    for (k_al = 0; k_al < 6; k_al = k_al + 1)
      if (act[k_al])
        var_alarm[asrc_q[k_al]] = 1'b1;
  end

  pad_fmt u_fmt (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (disp_req && !f_busy),
    .value    (scaled_q[disp_idx]),
    .ndig     (screen_digits(screen_q, font_q)),
    .fmt      (fmt_q[disp_idx]),
    .busy_q   (f_busy),
    .done_q   (f_done),
    .over_q   (f_over),
    .dp_q     (f_dp),
    .chars_q  (f_chars)
  );

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
      alarm_closed_q <= 6'h0;
      flash_cnt_q <= 24'h0;
      flash_ph_q <= 1'b0;
      var_invert_q <= 8'h0;
      disp_var_q <= 3'h0;
      disp_chars_q <= 136'h0;
      disp_dp_q <= 3'h0;
      disp_over_q <= 1'b0;
      disp_done_q <= 1'b0;
      status_show_q <= 1'b0;
      status_good_q <= 1'b0;
      txt_char_q <= 8'h0;
      summ_q <= 8'h0;
    end else begin
      pwr_s1_q <= bus_power;
      pwr_s2_q <= pwr_s1_q;
      // contact state is polarity inverted by alarm
      // absent bus power opens every contact
      alarm_closed_q <= pwr_s2_q ? (apol_q ^ act) : 6'h0;
      if (flash_cnt_q == FLASH_HALF_CYC[23:0] - 24'd1) begin
        flash_cnt_q <= 24'h0;
        flash_ph_q <= ~flash_ph_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 24'd1;
      end
      // bad status inverts, alarm toggles it
      var_invert_q <= ~good_q ^ (var_alarm & {8{flash_ph_q}});
      if (disp_req && !f_busy)
        disp_var_q <= disp_idx;
      disp_done_q <= f_done;
      if (f_done) begin
        disp_chars_q <= f_chars;
        disp_dp_q <= f_dp;
        disp_over_q <= f_over;
      end
      // status word only on screens 1 and 4
      status_show_q <= stat_txt_q && (screen_q == 4'd1 || screen_q == 4'd4);
      status_good_q <= good_q[disp_var_q];
      txt_char_q <= txt_unit ? unit_q[{txt_idx, txt_pos[2:0]}] : tag_q[{txt_idx, txt_pos}];
      if (summ_chan < 3'd6)
        summ_q <= {asrc_q[summ_chan], aen_q[summ_chan], apol_q[summ_chan], act[summ_chan]};
      else
        summ_q <= 8'h0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qa_grant_q <= 1'b0;
      qa_deny_q <= 1'b0;
      qa_mode_q <= 1'b0;
      bright_q <= `PAD_RST_BRIGHT;
      contrast_q <= `PAD_RST_CONTRAST;
    end else begin
      qa_grant_q <= 1'b0;
      qa_deny_q <= 1'b0;
      if (!qa_mode_q) begin
        if (qa_req) begin
          if (quick_en_q && (qcode_q == `PAD_RST_QCODE || qa_code == qcode_q)) begin
            qa_grant_q <= 1'b1;
            qa_mode_q <= 1'b1;
          end else begin
            qa_deny_q <= 1'b1;
          end
        end
      end else begin
        // quick mode reaches only brightness and contrast
        if (qa_we) begin
          bright_q <= qa_bright;
          contrast_q <= qa_contrast;
        end
        if (qa_exit)
          qa_mode_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* process_alarm_display_logic_test.sv */
// self-checking bench for the process alarm display block
`timescale 1ns/10ps
`default_nettype none
`include "pad_defs.vh"
module process_alarm_display_logic_test;
  logic         core_clk, rst, pv_we, pv_good, bus_power, cfg_we, sp_digit_we, sp_next;
  logic         sp_commit, sp_neg, qa_req, qa_we, qa_exit, disp_req, txt_unit;
  logic         disp_over_q, disp_done_q, status_show_q, status_good_q, menu_up_q;
  logic         qa_grant_q, qa_deny_q, qa_mode_q;
  logic [1:0]   sp_kind;
  logic [2:0]   pv_idx, cfg_var, sp_chan, disp_idx, txt_idx, summ_chan, disp_dp_q;
  logic [2:0]   sp_digit_ptr_q;
  logic [3:0]   cfg_sel, cfg_pos, sp_digit_val, txt_pos, screen_q;
  logic [5:0]   alarm_closed_q;
  logic [6:0]   qa_bright, qa_contrast, bright_q, contrast_q;
  logic [7:0]   var_invert_q, txt_char_q, summ_q;
  logic [31:0]  pv_value, cfg_data, qa_code;
  logic [135:0] disp_chars_q;
  int           mismatches, n_compared;
  pad_top #(.FLASH_HALF_CYC(8)) pad_top_i (.*);
  pad_host pad_host_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [135:0] got, input logic [135:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task cfg(input [3:0] s, input [2:0] v, input [3:0] p, input [31:0] d);
    @(posedge core_clk);
    {cfg_we, cfg_sel, cfg_var, cfg_pos, cfg_data} <= {1'b1, s, v, p, d};
    @(posedge core_clk);
    cfg_we <= 1'b0;
  endtask
  task sp_set(input [2:0] ch, input [1:0] k, input [23:0] d);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      {sp_digit_we, sp_next, sp_digit_val} <= {2'b11, d[23 - 4 * i -: 4]};
    end
    @(posedge core_clk);
    {sp_digit_we, sp_next, sp_commit, sp_chan, sp_kind} <= {3'b001, ch, k};
    @(posedge core_clk);
    sp_commit <= 1'b0;
    #1;
    chk({menu_up_q, sp_digit_ptr_q}, 4'h8);
  endtask
  task qa(input [31:0] c, input [1:0] exp);
    @(posedge core_clk);
    {qa_req, qa_code} <= {1'b1, c};
    @(posedge core_clk);
    qa_req <= 1'b0;
    #1;
    chk({qa_grant_q, qa_deny_q}, exp);
  endtask
  task qa_leave;
    @(posedge core_clk);
    qa_exit <= 1'b1;
    @(posedge core_clk);
    qa_exit <= 1'b0;
  endtask
  task disp(input [2:0] i);
    @(posedge core_clk);
    {disp_req, disp_idx} <= {1'b1, i};
    @(posedge core_clk);
    disp_req <= 1'b0;
    for (int n = 0; n < 30 && disp_done_q !== 1'b1; n++)
      cyc(1);
    chk(disp_done_q, 1'b1);
  endtask
  task t_reset;
    cyc(4);
    chk({alarm_closed_q, var_invert_q}, 14'h3FFF);
    chk({bright_q, contrast_q, screen_q}, {`PAD_RST_BRIGHT, `PAD_RST_CONTRAST, 4'h1});
  endtask
  task t_alarm;
    int hi;
    cfg(`PAD_CFG_GAIN, 3'h2, 4'h0, 32'h200);
    cfg(`PAD_CFG_OFFSET, 3'h2, 4'h0, 32'hA);
    cfg(`PAD_CFG_ASRC, 3'h0, 4'h0, 32'h2);
    cfg(`PAD_CFG_APOL, 3'h0, 4'h0, 32'h0);
    cfg(`PAD_CFG_AEN, 3'h0, 4'h0, 32'h2);
    sp_set(3'h0, `PAD_SP_HI, 24'h001000);
    cyc(2);
    chk(alarm_closed_q, 6'h3E);
    pad_host_i.send(3'h2, 32'd50000, 1'b1);
    cyc(3);
    chk(alarm_closed_q, 6'h3F);
    hi = 0;
    repeat (20) begin
      cyc(1);
      hi += var_invert_q[2];
    end
    chk(hi > 0 && hi < 20, 1'b1);
    pad_host_i.send(3'h2, 32'd49990, 1'b1);
    cyc(3);
    chk(alarm_closed_q, 6'h3E);
    pad_host_i.send(3'h2, 32'd50000, 1'b0);
    cyc(3);
    chk({alarm_closed_q, var_invert_q[2]}, 7'h7D);
    cfg(`PAD_CFG_GLOBAL, 3'h0, 4'h0, 32'h6);
    pad_host_i.send(3'h2, 32'd50000, 1'b0);
    cyc(3);
    chk(alarm_closed_q, 6'h3F);
    cfg(`PAD_CFG_GLOBAL, 3'h0, 4'h0, 32'h7);
    pad_host_i.set_power(1'b0);
    cyc(4);
    chk(alarm_closed_q, 6'h00);
    pad_host_i.set_power(1'b1);
    cyc(4);
    chk(alarm_closed_q, 6'h3F);
    @(posedge core_clk);
    summ_chan <= 3'h0;
    cyc(2);
    chk(summ_q, 8'h49);
    @(posedge core_clk);
    summ_chan <= 3'h1;
    cyc(2);
    chk(summ_q, 8'h02);
    cfg(`PAD_CFG_AEN, 3'h0, 4'h0, 32'h6);
    sp_set(3'h0, `PAD_SP_HYS, 24'h000050);
    pad_host_i.send(3'h2, 32'd49990, 1'b1);
    cyc(3);
    chk(alarm_closed_q, 6'h3F);
    pad_host_i.send(3'h2, 32'd47000, 1'b1);
    cyc(3);
    chk(alarm_closed_q, 6'h3E);
  endtask
  task t_fmt;
    logic [31:0] v [4];
    logic [39:0] e [4];
    v = '{32'd12340, 32'd340, -32'sd12340, 32'd1234000};
    e = '{40'h2031323334, 40'h2030303334, 40'h2D31323334, 40'h3F3F3F3F3F};
    cfg(`PAD_CFG_SCREEN, 3'h0, 4'h0, 32'h3);
    cfg(`PAD_CFG_FORMAT, 3'h1, 4'h0, 32'h2);
    for (int k = 0; k < 4; k++) begin
      pad_host_i.send(3'h1, v[k], 1'b1);
      cyc(3);
      disp(3'h1);
      chk(disp_chars_q, {{12{8'h20}}, e[k]});
      chk(disp_over_q, k == 3);
      if (k == 0)
        chk(disp_dp_q, 3'h3);
    end
  endtask
  task t_qa;
    qa(32'h31323334, 2'b10);
    cfg(`PAD_CFG_SCREEN, 3'h0, 4'h0, 32'h5);
    @(posedge core_clk);
    {qa_we, qa_bright, qa_contrast} <= {1'b1, 7'h10, 7'h20};
    @(posedge core_clk);
    qa_we <= 1'b0;
    qa_leave;
    cyc(1);
    chk({qa_mode_q, bright_q, contrast_q, screen_q}, {1'b0, 7'h10, 7'h20, 4'h3});
    cfg(`PAD_CFG_QCODE, 3'h0, 4'h0, 32'h41623132);
    qa(32'h61623132, 2'b01);
    qa(32'h41623132, 2'b10);
    qa_leave;
    cfg(`PAD_CFG_GLOBAL, 3'h0, 4'h0, 32'h3);
    qa(32'h41623132, 2'b01);
  endtask
  task t_text;
    cfg(`PAD_CFG_TAG, 3'h3, 4'hF, 32'h5A);
    cfg(`PAD_CFG_UNIT, 3'h3, 4'h7, 32'h75);
    @(posedge core_clk);
    {txt_idx, txt_pos, txt_unit} <= {3'h3, 4'hF, 1'b0};
    cyc(2);
    chk(txt_char_q, 8'h5A);
    @(posedge core_clk);
    {txt_pos, txt_unit} <= {4'h7, 1'b1};
    cyc(2);
    chk(txt_char_q, 8'h75);
    cfg(`PAD_CFG_SCREEN, 3'h0, 4'h0, 32'h4);
    cyc(1);
    chk({status_show_q, status_good_q}, 2'b11);
    cfg(`PAD_CFG_GLOBAL, 3'h0, 4'h0, 32'h1);
    cyc(1);
    chk(status_show_q, 1'b0);
  endtask
  task final_report;
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst, cfg_we, sp_digit_we, sp_next, sp_commit, sp_neg, qa_req, qa_we} = 8'h80;
    {qa_exit, disp_req, txt_unit, sp_kind, cfg_var, sp_chan, disp_idx} = '0;
    {txt_idx, summ_chan, cfg_sel, cfg_pos, sp_digit_val, txt_pos} = '0;
    {qa_bright, qa_contrast, cfg_data, qa_code} = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_alarm;
    t_fmt;
    t_qa;
    t_text;
    final_report;
  end
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
